// ===== hw/eiu_ext_irq.sv
`default_nettype none
module eiu_ext_irq
#(
   parameter int NPINS = 2
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // AHB-Lite slave
   input wire eiu_pkg::eiu_ahb_s ahb,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Interrupt pins and watchdog sampling clock
   input wire logic ext_irq_pin_a,
   input wire logic ext_irq_pin_b,
   input wire logic wdt_osc,
   // Core and power state
   input wire logic io_clk_halted,
   input wire logic startup_busy,
   input wire logic ack_a,
   input wire logic ack_b,
   // Requests to the core
   output logic irq_vec_a,
   output logic irq_vec_b,
   output logic irq,
   output logic wake_req
);
   if (NPINS != 2)
   begin : g_chk
      $error("eiu_ext_irq: register layout holds exactly two pins");
   end

   // ***************************************************************
   // Pin sampling
   // ***************************************************************
   logic [NPINS:0] raw;
   logic [NPINS:0] synced;
   logic [NPINS-1:0] pin_s;
   logic wdt_s;
   // Pad levels are taken whatever the pin direction
   assign raw = {wdt_osc, ext_irq_pin_b, ext_irq_pin_a};
   eiu_sync #(.W(NPINS + 1)) u_sync
   (
      .clk(clk),
      .reset(reset),
      .d(raw),
      .q(synced)
   );
   assign pin_s = synced[NPINS-1:0];
   assign wdt_s = synced[NPINS];

   // ***************************************************************
   // Registers
   // ***************************************************************
   eiu_pkg::eiu_reg_t mcu_q, mcu_d, gic_q, gic_d;
   logic [NPINS-1:0] flags_q, flags_d, prev_q, vec_q, vec_d;
   logic gie_q, gie_d, armed_q, wdt_prev_q, wake_q, wake_d, irq_q;
   logic [1:0] lowcnt_q [NPINS];
   logic [1:0] lowcnt_d [NPINS];
   logic [31:0] hrdata_q, hrdata_d;
   logic hreadyout_q, wr_q, whi_q;
   logic [eiu_pkg::ADDR_W-1:0] waddr_q;

   // ***************************************************************
   // Bus decode
   // ***************************************************************
   logic ap, hi_ok, wsel_mcu, wsel_gic, wsel_flags, wsel_status_register;
   logic [eiu_pkg::ADDR_W-1:0] ra;
   eiu_pkg::eiu_reg_t wdat, rd_byte, flags_rd, status_register_rd, live_rd;
   assign ap = ahb.hsel && ahb.htrans[eiu_pkg::HTRANS_ACT_BIT] && ahb.hready;
   assign ra = ahb.haddr[eiu_pkg::ADDR_W-1:0];
   assign hi_ok = (ahb.haddr[31:eiu_pkg::ADDR_W] == '0);
   assign flags_rd = eiu_pkg::eiu_reg_t'(flags_q) << eiu_pkg::FLAG_LSB;
   assign status_register_rd = eiu_pkg::eiu_reg_t'(gie_q) << eiu_pkg::GIE_BIT;
   assign live_rd = eiu_pkg::eiu_reg_t'({wake_q, pin_s});
   // Unmapped words read as zero; all answers are OKAY with no wait
   assign rd_byte = !hi_ok ? '0 :
      (ra == eiu_pkg::OFS_MCU_CTRL) ? mcu_q :
      (ra == eiu_pkg::OFS_GIC) ? gic_q :
      (ra == eiu_pkg::OFS_FLAGS) ? flags_rd :
      (ra == eiu_pkg::OFS_STATUS_REGISTER) ? status_register_rd :
      (ra == eiu_pkg::OFS_LIVE) ? live_rd : '0;
   assign hrdata_d = (ap && !ahb.hwrite) ? 32'(rd_byte) : '0;
   // Writes land at the end of the data phase, when hwdata stands
   assign wdat = ahb.hwdata[eiu_pkg::REG_W-1:0];
   assign wsel_mcu = wr_q && whi_q && (waddr_q == eiu_pkg::OFS_MCU_CTRL);
   assign wsel_gic = wr_q && whi_q && (waddr_q == eiu_pkg::OFS_GIC);
   assign wsel_flags = wr_q && whi_q && (waddr_q == eiu_pkg::OFS_FLAGS);
   assign wsel_status_register = wr_q && whi_q && (waddr_q == eiu_pkg::OFS_STATUS_REGISTER);
   assign mcu_d = wsel_mcu ? wdat : mcu_q;
   assign gic_d = wsel_gic ? (wdat & eiu_pkg::GIC_WR_MASK) : gic_q;
   assign gie_d = wsel_status_register ? wdat[eiu_pkg::GIE_BIT] : gie_q;

   // ***************************************************************
   // Per-pin sensing
   // ***************************************************************
   eiu_pkg::eiu_sense_e sense [NPINS];
   logic [NPINS-1:0] en, lvl_mode, lvl, rise, fall, ev, clr, w1c, ack, req, wake_src;
   logic wdt_tick;
   assign ack = {ack_b, ack_a};
   assign wdt_tick = wdt_s && !wdt_prev_q;
   for (genvar i = 0; i < NPINS; i++)
   begin : g_pin
      // Pin a field at bits 1:0, pin b at 3:2
      assign sense[i] = eiu_pkg::eiu_sense_e'(
         mcu_q[eiu_pkg::SENSE_LSB + i * eiu_pkg::SENSE_W +: eiu_pkg::SENSE_W]);
      assign en[i] = gic_q[eiu_pkg::EN_LSB + i];
      assign w1c[i] = wsel_flags && wdat[eiu_pkg::FLAG_LSB + i];
      assign lvl_mode[i] = (sense[i] == eiu_pkg::SENSE_LOW);
      // Level path does not look at the I/O clock state
      assign lvl[i] = lvl_mode[i] && !pin_s[i];
      assign rise[i] = !prev_q[i] && pin_s[i];
      assign fall[i] = prev_q[i] && !pin_s[i];
      // Edges are lost while the I/O clock is halted, as on the real part
      assign ev[i] = armed_q && !io_clk_halted && (
         (sense[i] == eiu_pkg::SENSE_ANY) ? (rise[i] || fall[i]) :
         (sense[i] == eiu_pkg::SENSE_FALL) ? fall[i] :
         (sense[i] == eiu_pkg::SENSE_RISE) ? rise[i] : 1'b0);
      assign clr[i] = ack[i] || w1c[i];
      // Set beats a clear in the same cycle
      assign flags_d[i] = lvl_mode[i] ? 1'b0 : (ev[i] || (flags_q[i] && !clr[i]));
      // Live level, nothing latched: the source must hold it long enough
      assign req[i] = gie_q && en[i] &&
         (flags_q[i] || (lvl[i] && !startup_busy));
      assign vec_d[i] = req[i];
      assign lowcnt_d[i] = !wdt_tick ? lowcnt_q[i] :
         pin_s[i] ? 2'h0 :
         (lowcnt_q[i] == eiu_pkg::WDT_SAMPLES) ? eiu_pkg::WDT_SAMPLES :
         2'(lowcnt_q[i] + 2'h1);
      assign wake_src[i] = gie_q && en[i] && lvl_mode[i] &&
         (lowcnt_q[i] == eiu_pkg::WDT_SAMPLES);
   end
   assign wake_d = io_clk_halted && (|wake_src);

   // ***************************************************************
   // State
   // ***************************************************************
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mcu_q <= eiu_pkg::MCU_RESET;
         gic_q <= eiu_pkg::GIC_RESET;
         gie_q <= 1'b0;
         flags_q <= '0;
      end
      else
      begin
         mcu_q <= mcu_d;
         gic_q <= gic_d;
         gie_q <= gie_d;
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         prev_q <= '0;
         armed_q <= 1'b0;
         wdt_prev_q <= 1'b0;
         lowcnt_q <= '{default: 2'h0};
      end
      else
      begin
         prev_q <= pin_s;
         armed_q <= 1'b1;
         wdt_prev_q <= wdt_s;
         lowcnt_q <= lowcnt_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         vec_q <= '0;
         irq_q <= 1'b0;
         wake_q <= 1'b0;
      end
      else
      begin
         vec_q <= vec_d;
         irq_q <= |req;
         wake_q <= wake_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         hrdata_q <= '0;
         hreadyout_q <= 1'b1;
         wr_q <= 1'b0;
         whi_q <= 1'b0;
         waddr_q <= '0;
      end
      else
      begin
         hrdata_q <= hrdata_d;
         hreadyout_q <= 1'b1;
         wr_q <= ap && ahb.hwrite;
         whi_q <= hi_ok;
         waddr_q <= ra;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign irq_vec_a = vec_q[0];
   assign irq_vec_b = vec_q[1];
   assign irq = irq_q;
   assign wake_req = wake_q;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_level_holds;
      gie_q && en[0] && lvl_mode[0] && !pin_s[0] && !startup_busy |=> irq_vec_a;
   endproperty
   a_level_holds: assert property (p_level_holds)
      else $error("level request on pin a not raised");

   property p_halt_no_edge;
      io_clk_halted && !flags_q[0] |=> !flags_q[0];
   endproperty
   a_halt_no_edge: assert property (p_halt_no_edge)
      else $error("edge flag set while io clock halted");

   property p_wake_cause;
      $rose(wake_req) |->
         $past(lowcnt_q[0] == eiu_pkg::WDT_SAMPLES || lowcnt_q[1] == eiu_pkg::WDT_SAMPLES);
   endproperty
   a_wake_cause: assert property (p_wake_cause)
      else $error("wake without two low watchdog samples");

   property p_startup_quiet;
      startup_busy && !flags_q[0] |=> !irq_vec_a;
   endproperty
   a_startup_quiet: assert property (p_startup_quiet)
      else $error("level request during start-up");

   property p_global_gate;
      !gie_q |=> !irq_vec_a && !irq_vec_b && !irq;
   endproperty
   a_global_gate: assert property (p_global_gate)
      else $error("request with global enable clear");

   property p_rise_a;
      sense[0] == eiu_pkg::SENSE_RISE && armed_q && !io_clk_halted && rise[0]
         |=> flags_q[0] ##1 (irq_vec_a == (gie_q && en[0]));
   endproperty
   a_rise_a: assert property (p_rise_a)
      else $error("rising edge on pin a missed");

   property p_fall_b;
      sense[1] == eiu_pkg::SENSE_FALL && armed_q && !io_clk_halted && !prev_q[1] ##1
         (pin_s[1] && !io_clk_halted) [*2] ##1 (!pin_s[1] && !io_clk_halted &&
         sense[1] == eiu_pkg::SENSE_FALL) |=> flags_q[1];
   endproperty
   a_fall_b: assert property (p_fall_b)
      else $error("two-period high pulse on pin b missed its falling edge");

   property p_ro_bits;
      wsel_gic |=> (gic_q & eiu_pkg::GIC_RO_MASK) == '0;
   endproperty
   a_ro_bits: assert property (p_ro_bits)
      else $error("read-only control bits took a write");

   property p_level_clears;
      lvl_mode[1] |=> !flags_q[1];
   endproperty
   a_level_clears: assert property (p_level_clears)
      else $error("pending flag set in level mode");

   property p_vec_b;
      gie_q && en[1] && flags_q[1] |=> irq_vec_b && irq;
   endproperty
   a_vec_b: assert property (p_vec_b)
      else $error("pending pin b did not reach its vector");

   property p_reset_state;
      $past(reset) |-> mcu_q == eiu_pkg::MCU_RESET && !en[0] && !en[1];
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("pins not disabled and low-sensed after reset");

   c_level_a: cover property (gie_q && lvl[0] ##1 irq_vec_a);
   c_any_b: cover property (sense[1] == eiu_pkg::SENSE_ANY && ev[1] ##1 flags_q[1]);
   c_wake: cover property (io_clk_halted ##[1:200] wake_req);
   c_w1c: cover property (flags_q[0] && w1c[0] ##1 !flags_q[0]);
endmodule
`default_nettype wire

// ===== hw/eiu_pkg.sv
// Notes on behaviour
// - Requests come from the pad level itself, so a pin driven as an output still interrupts.
// - In low-level mode an enabled pin keeps its request up for as long as the pin is low, except while start-up is busy.
// - Rise and fall detection runs on the I/O clock and sees nothing while it is halted.
// - Low-level detection does not need the I/O clock and can wake the part from deep sleep.
// - A wake by level needs the low level seen at two successive watchdog clock samples.
// - A level that passes both samples but is gone by the end of start-up wakes, no request.
// - A pin requests only while both the global enable and its own enable bit are set.
// - The pin is sampled before edge detection; a pulse over one clock period is caught.
// - Pin b sense at control bits 3:2: 00 low, 01 any change, 10 falling, 11 rising.
// - Pin a sense at control bits 1:0 with the same coding as pin b.
// - Enable b sits at bit 7, enable a at bit 6, bits 5 to 2 read zero and ignore writes.
// - Each pin has its own request line towards its own vector.
// - An event sets the pin's pending flag; handler or a written one clears it; level mode
//           keeps it clear.
`default_nettype none
package eiu_pkg;
   // ***************************************************************
   // Register map and fields
   // ***************************************************************
   localparam int ADDR_W = 5;
   localparam int REG_W = 8;
   localparam logic [ADDR_W-1:0] OFS_MCU_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_GIC = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS_REGISTER = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_LIVE = 5'h10;
   localparam logic [REG_W-1:0] MCU_RESET = 8'h00;
   localparam logic [REG_W-1:0] GIC_RESET = 8'h00;
   localparam logic [REG_W-1:0] GIC_WR_MASK = 8'hc3;
   localparam logic [REG_W-1:0] GIC_RO_MASK = 8'h3c;
   localparam int SENSE_LSB = 0;
   localparam int SENSE_W = 2;
   localparam int EN_LSB = 6;
   localparam int FLAG_LSB = 6;
   localparam int GIE_BIT = 0;
   localparam int HTRANS_ACT_BIT = 1;
   localparam logic [1:0] WDT_SAMPLES = 2'h2;
   typedef logic [REG_W-1:0] eiu_reg_t;
   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0]
   {
      SENSE_LOW = 2'b00,
      SENSE_ANY = 2'b01,
      SENSE_FALL = 2'b10,
      SENSE_RISE = 2'b11
   } eiu_sense_e;
   typedef struct packed
   {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } eiu_ahb_s;
endpackage
`default_nettype wire

// ===== hw/eiu_sync.sv
`default_nettype none
module eiu_sync
#(
   parameter int W = 1
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   if (W < 1)
   begin : g_chk
      $error("eiu_sync: width must be at least one");
   end
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   // Only the second stage is visible outside
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end
   assign q = sync_q;
endmodule
`default_nettype wire

// ===== verif/eiu_pin_src.sv
`default_nettype none
module eiu_pin_src
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Levels asked for by the bench
   input wire logic lvl_a,
   input wire logic lvl_b,
   // Pads and slow sampling clock
   output logic pin_a,
   output logic pin_b,
   output logic wdt_osc
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] div_q;
   // Pads follow the commanded level and keep it as long as asked
   assign pin_a = lvl_a;
   assign pin_b = lvl_b;
   // Free-running slow oscillator, four clk periods a phase so each phase is seen
   always_ff @(posedge clk)
   begin
      div_q <= reset ? 2'h0 : div_q + 2'h1;
      if (reset)
         wdt_osc <= 1'b0;
      else if (div_q == 2'h3)
         wdt_osc <= ~wdt_osc;
   end
endmodule
`default_nettype wire

// ===== verif/test_external_pin_interrupt_unit.sv
`default_nettype none
module test_external_pin_interrupt_unit;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] A_MCU = 32'(eiu_pkg::OFS_MCU_CTRL);
   localparam logic [31:0] A_GIC = 32'(eiu_pkg::OFS_GIC);
   localparam logic [31:0] A_FLG = 32'(eiu_pkg::OFS_FLAGS);
   localparam logic [31:0] A_SRG = 32'(eiu_pkg::OFS_STATUS_REGISTER);
   localparam logic [31:0] A_LIV = 32'(eiu_pkg::OFS_LIVE);
   logic clk, reset, m_sel, m_write, lvl_a, lvl_b, halted, busy, ack_a, ack_b;
   logic [31:0] m_addr, m_wdata, hrdata;
   logic [1:0] m_trans;
   logic hreadyout, hresp, pin_a, pin_b, wdt_osc, vec_a, vec_b, irq, wake;
   int errors, checked, cycles;
   wire eiu_pkg::eiu_ahb_s ahb_w;
   assign ahb_w = {m_sel, m_addr, m_trans, m_write, 3'h2, m_wdata, hreadyout};
   eiu_pin_src eiu_pin_src_i (.clk(clk), .reset(reset), .lvl_a(lvl_a), .lvl_b(lvl_b),
      .pin_a(pin_a), .pin_b(pin_b), .wdt_osc(wdt_osc));
   eiu_ext_irq eiu_ext_irq_i (.clk(clk), .reset(reset), .ahb(ahb_w), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
      .wdt_osc(wdt_osc), .io_clk_halted(halted), .startup_busy(busy), .ack_a(ack_a),
      .ack_b(ack_b), .irq_vec_a(vec_a), .irq_vec_b(vec_b), .irq(irq), .wake_req(wake));
   // ***************************************************************
   // Helpers
   // ***************************************************************
   task automatic give_verdict();
      if (errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp || hresp !== 1'b0 || hreadyout !== 1'b1)
      begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Single word transfer; called just after a rising edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d,
      output logic [31:0] r);
      m_sel <= 1'b1;
      m_addr <= a;
      m_trans <= 2'h2;
      m_write <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      m_sel <= 1'b0;
      m_trans <= 2'h0;
      m_wdata <= {24'h0, d};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 8'h00, r);
      chk(r, e);
   endtask
   task automatic set_pin(input int p, input logic v);
      if (p == 0)
         lvl_a <= v;
      else
         lvl_b <= v;
   endtask
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_regs();
      rdc(A_MCU, 32'h0);
      rdc(A_GIC, 32'h0);
      rdc(32'h0000_0020, 32'h0);
      wr(A_GIC, 8'hff);
      rdc(A_GIC, {24'h0, eiu_pkg::GIC_WR_MASK});
      wr(A_MCU, 8'hff);
      rdc(A_MCU, 32'h0000_00ff);
      wr(A_MCU, 8'h00);
      wr(A_GIC, 8'h00);
   endtask
   task automatic t_edges();
      logic [7:0] fb;
      wr(A_SRG, 8'h01);
      for (int p = 0; p < 2; p++)
         for (int m = 1; m < 4; m++)
         begin
            fb = 8'(8'h40 << p);
            wr(A_MCU, 8'(m << (2 * p)));
            wr(A_GIC, fb);
            set_pin(p, 1'b0);
            repeat (6) @(posedge clk);
            chk({31'h0, (p == 0) ? vec_a : vec_b}, {31'h0, m != 3});
            rdc(A_FLG, (m != 3) ? {24'h0, fb} : 32'h0);
            wr(A_FLG, fb);
            set_pin(p, 1'b1);
            repeat (6) @(posedge clk);
            rdc(A_FLG, (m != 2) ? {24'h0, fb} : 32'h0);
            wr(A_FLG, fb);
         end
   endtask
   task automatic t_ack();
      for (int p = 0; p < 2; p++)
      begin
         wr(A_MCU, 8'(8'h3 << (2 * p)));
         wr(A_GIC, 8'(8'h40 << p));
         set_pin(p, 1'b0);
         repeat (3) @(posedge clk);
         set_pin(p, 1'b1);
         repeat (6) @(posedge clk);
         chk({30'h0, vec_b, vec_a}, 32'(1 << p));
         if (p == 0)
            ack_a <= 1'b1;
         else
            ack_b <= 1'b1;
         @(posedge clk);
         ack_a <= 1'b0;
         ack_b <= 1'b0;
         repeat (3) @(posedge clk);
         chk({30'h0, vec_b, vec_a}, 32'h0);
      end
      // Two-period high pulse on pin b under falling-edge sense
      wr(A_MCU, 8'h08);
      wr(A_GIC, 8'h80);
      lvl_b <= 1'b0;
      repeat (6) @(posedge clk);
      wr(A_FLG, 8'h80);
      lvl_b <= 1'b1;
      repeat (2) @(posedge clk);
      lvl_b <= 1'b0;
      repeat (6) @(posedge clk);
      rdc(A_FLG, 32'h0000_0080);
      wr(A_FLG, 8'h80);
      lvl_b <= 1'b1;
   endtask
   task automatic t_level();
      wr(A_SRG, 8'h00);
      wr(A_MCU, 8'h00);
      wr(A_GIC, 8'h40);
      lvl_a <= 1'b0;
      repeat (8) @(posedge clk);
      chk({31'h0, vec_a}, 32'h0);
      wr(A_SRG, 8'h01);
      repeat (24) @(posedge clk);
      chk({30'h0, irq, vec_a}, 32'h3);
      rdc(A_FLG, 32'h0);
      busy <= 1'b1;
      repeat (4) @(posedge clk);
      chk({31'h0, vec_a}, 32'h0);
      busy <= 1'b0;
      lvl_a <= 1'b1;
      repeat (6) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic t_sleep();
      halted <= 1'b1;
      wr(A_MCU, 8'h03);
      lvl_a <= 1'b0;
      repeat (3) @(posedge clk);
      lvl_a <= 1'b1;
      repeat (6) @(posedge clk);
      rdc(A_FLG, 32'h0);
      wr(A_MCU, 8'h00);
      lvl_a <= 1'b0;
      repeat (30) @(posedge clk);
      chk({31'h0, wake}, 32'h1);
      rdc(A_LIV, 32'h0000_0006);
      lvl_a <= 1'b1;
      halted <= 1'b0;
      repeat (20) @(posedge clk);
      chk({31'h0, wake}, 32'h0);
   endtask
   // ***************************************************************
   // Run
   // ***************************************************************
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         give_verdict();
      end
   end
   initial
   begin
      {errors, checked, cycles} = '0;
      {reset, lvl_a, lvl_b} = 3'b111;
      {m_sel, m_write, halted, busy, ack_a, ack_b, m_trans} = '0;
      {m_addr, m_wdata} = '0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk({29'h0, irq, vec_b, vec_a}, 32'h0);
      t_regs();
      t_edges();
      t_ack();
      t_level();
      t_sleep();
      give_verdict();
   end
endmodule
`default_nettype wire
